// file: rtl/ppx_divstep.sv
// Shared constants for the transfer core, and its one-bit unsigned divide step.
`timescale 1ns/1ns
`default_nettype none

package ppx_pkg;
	// ----------------------------------------------------------------
	// Register map (byte offsets on the Wishbone bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD    = 8'h00; // Command word, write starts it
	localparam logic [7:0] ADDR_BASE   = 8'h04; // Address base
	localparam logic [7:0] ADDR_OFFS   = 8'h08; // Address offset
	localparam logic [7:0] ADDR_STAT   = 8'h0C; // Status, read only
	localparam logic [7:0] ADDR_FUNC   = 8'h10; // Function register
	localparam logic [7:0] ADDR_FEFF   = 8'h14; // Function value in effect, read only
	localparam logic [7:0] ADDR_CREG   = 8'h20; // Core registers 0..7, one word each
	localparam logic [7:0] ADDR_CREG_M = 8'hE0; // Mask that picks the core window
	// ----------------------------------------------------------------
	// Command word fields
	// ----------------------------------------------------------------
	localparam int CMD_OP_LSB   = 0;  // Operation, 4 bits
	localparam int CMD_SIZE_LSB = 4;  // Size, 2 bits
	localparam int CMD_ITEM_LSB = 6;  // Item, 2 bits
	localparam int CMD_SIGN     = 8;  // 1 = signed
	localparam int CMD_GLOB     = 9;  // Global unit
	localparam int CMD_CEN      = 10; // Condition in use
	localparam int CMD_CNEG     = 11; // Condition inverted
	localparam int CMD_CSEL_LSB = 12; // Flag tested, 2 bits
	localparam int CMD_PRO      = 14; // Protect status flags
	localparam int CMD_CMP      = 15; // Complement function register
	localparam int CMD_DST_LSB  = 16; // Destination, 3 bits
	localparam int CMD_SRC_LSB  = 20; // Source, 3 bits
	localparam int CMD_SRC2_LSB = 24; // Second source, 3 bits
	localparam int CMD_DST2_LSB = 28; // Second destination, 3 bits
	// ----------------------------------------------------------------
	// Status word fields
	// ----------------------------------------------------------------
	localparam int STAT_BUSY  = 0;
	localparam int STAT_GIE   = 1;
	localparam int STAT_LOOP  = 2;
	localparam int STAT_QWAIT = 3;
	localparam int STAT_GUSED = 4;
	localparam int STAT_FLAG  = 8; // N C V Z at 11..8
	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PPX_NOP, PPX_DINT, PPX_EINT, PPX_DLOOP, PPX_ELOOP, PPX_QWAIT, PPX_DIVI,
		PPX_LOAD, PPX_STORE, PPX_ADDR, PPX_MOVE, PPX_EXTR, PPX_REPL, PPX_FUNC
	} ppx_op_type;
	localparam logic [1:0] SIZE_WORD = 2'h0; // Default when no size is given
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_HALF = 2'h2;
	localparam logic [1:0] CSEL_Z = 2'h0;
	localparam logic [1:0] CSEL_N = 2'h1;
	localparam logic [1:0] CSEL_C = 2'h2;
	localparam logic [1:0] CSEL_V = 2'h3;
	localparam logic        RST_GIE  = 1'b0;
	localparam logic        RST_LOOP = 1'b0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : ppx_pkg

module ppx_divstep #(
	parameter int W = 32 // Operand width
) (
	input  wire logic [W-1:0] rem_i,  // Partial remainder
	input  wire logic [W-1:0] quo_i,  // Dividend bits shifting out, quotient shifting in
	input  wire logic [W-1:0] div_i,  // Divisor
	output logic      [W-1:0] rem_o,  // Next remainder
	output logic      [W-1:0] quo_o,  // Next quotient shift value
	output logic              qbit_o  // Quotient bit of this step
);
	logic [W:0] trial; // Shifted remainder with carry room
	logic [W:0] diff;  // Trial subtraction
	// One step only: W executions make the full quotient
	always_comb begin
		trial  = {rem_i, quo_i[W-1]}; // RULE1
		diff   = trial - {1'b0, div_i};
		qbit_o = ~diff[W]; // RULE2
		rem_o  = qbit_o ? diff[W-1:0] : trial[W-1:0];
		quo_o  = {quo_i[W-2:0], qbit_o};
	end
endmodule : ppx_divstep

`default_nettype wire

// file: rtl/ppx_core.sv
// Data-unit misc ops, divide step and parallel transfers behind a Wishbone slave.
//
// Operation
// RULE1: Divide executes one unsigned step only
// RULE2: Each step yields one quotient bit
// RULE3: Disable clears, enable sets global interrupts
// RULE4: Loop enable and disable instructions
// RULE5: No-op changes nothing in data unit
// RULE6: Queue wait stalls until flag zero
// RULE7: Load writes memory word into register
// RULE8: Store writes register into memory
// RULE9: Address op writes address, no access
// RULE10: Extract right-aligns byte/half, zero or sign
// RULE11: Replicate low byte/half across word
// RULE12: Size picks byte/half/word, word default
// RULE13: Item picks byte or halfword part
// RULE14: Sign picks zero or sign extension
// RULE15: Complement option inverts function register
// RULE16: Global move goes through global path
// RULE17: Protect keeps status flags unchanged
// RULE18: Move copies register, no memory
// RULE19: False condition leaves destination unchanged
// RULE20: Narrow store enables only addressed lanes
`timescale 1ns/1ns
`default_nettype none

module ppx_core (
	input  wire logic        clk_i,       // 50 MHz core clock
	input  wire logic        rst_i,       // Synchronous reset, active high
	// Wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Memory port toward the crossbar
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic      [31:0] mem_addr_o,
	output logic      [3:0]  mem_be_o,
	output logic      [31:0] mem_wdata_o,
	input  wire logic        mem_ack_i,
	input  wire logic [31:0] mem_rdata_i,
	// Core controls and status
	input  wire logic        comm_q_i,    // Queue flag from the comm register, async
	output logic             gie_o,       // Global interrupt enable
	output logic             loop_en_o,   // Hardware looping enable
	output logic             stall_o,     // Instruction flow stalled
	output logic             gpath_o      // Global unit path busy
);
	import ppx_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum {ST_IDLE, ST_EXEC, ST_MEM, ST_GLOB, ST_QWAIT} ppx_state_type;
	ppx_state_type state;            // Sequencer state
	logic [31:0]   cmd;              // Latched command
	logic [31:0]   base;             // Address base
	logic [31:0]   offs;             // Address offset
	logic [31:0]   func;             // Function register
	logic [31:0]   creg [8];         // Core registers
	logic [3:0]    flags;            // N C V Z
	logic          gused;            // Last move went through global unit
	logic          q_meta;           // Queue flag, first sync stage
	logic          q_sync;           // Queue flag, synchronised
	logic          cond_ok;          // Condition true for this command
	logic [31:0]   gbuf;             // Global path holding register

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	ppx_op_type  op;
	logic [1:0]  size;
	logic [1:0]  item;
	logic        sgn;
	logic [2:0]  dst;
	logic [31:0] srcv;               // Source register value
	logic [31:0] src2v;              // Second source value
	logic [31:0] dstv;               // Destination register value
	logic [31:0] ea;                 // Effective address
	logic [31:0] feff;               // Function value in effect
	logic        bus_req;            // New bus access this cycle
	logic        cmd_wr;             // Command write accepted
	assign op    = ppx_op_type'(cmd[CMD_OP_LSB +: 4]);
	assign size  = cmd[CMD_SIZE_LSB +: 2];
	assign item  = cmd[CMD_ITEM_LSB +: 2];
	assign sgn   = cmd[CMD_SIGN];
	assign dst   = cmd[CMD_DST_LSB +: 3];
	assign srcv  = creg[cmd[CMD_SRC_LSB +: 3]];
	assign src2v = creg[cmd[CMD_SRC2_LSB +: 3]];
	assign dstv  = creg[dst];
	assign ea    = base + offs;
	assign feff  = cmd[CMD_CMP] ? ~func : func; // RULE15
	assign bus_req = cyc_i & stb_i & ~ack_o;
	// Commands arriving while busy are dropped; software polls busy first
	assign cmd_wr  = bus_req & we_i & (adr_i == ADDR_CMD) & (state == ST_IDLE);

	// ----------------------------------------------------------------
	// Field helpers
	// ----------------------------------------------------------------
	// Takes a byte or half at a lane and right-aligns it with fill
	function automatic logic [31:0] ppx_pick(input logic [31:0] v, input logic [1:0] sz,
		input logic [1:0] part, input logic s);
		logic [7:0]  b;
		logic [15:0] h;
		b = v[{part, 3'h0} +: 8];
		h = v[{part[0], 4'h0} +: 16];
		case (sz)
			SIZE_BYTE: ppx_pick = {{24{s & b[7]}}, b};    // RULE10 RULE14
			SIZE_HALF: ppx_pick = {{16{s & h[15]}}, h};   // RULE10 RULE13 RULE14
			default:   ppx_pick = v;                      // RULE12
		endcase
	endfunction : ppx_pick

	// Replicates the low byte or half across the word
	function automatic logic [31:0] ppx_repl(input logic [31:0] v, input logic [1:0] sz);
		case (sz)
			SIZE_BYTE: ppx_repl = {4{v[7:0]}};   // RULE11
			SIZE_HALF: ppx_repl = {2{v[15:0]}};  // RULE11
			default:   ppx_repl = v;
		endcase
	endfunction : ppx_repl

	// ----------------------------------------------------------------
	// Divide step
	// ----------------------------------------------------------------
	logic [31:0] div_rem;            // Next remainder into dst
	logic [31:0] div_quo;            // Next quotient into dst2
	logic        div_qbit;           // Quotient bit of the step
	ppx_divstep #(.W(32)) u_div (
		.rem_i  (dstv),
		.quo_i  (srcv),
		.div_i  (src2v),
		.rem_o  (div_rem),
		.quo_o  (div_quo),
		.qbit_o (div_qbit)
	);

	// ----------------------------------------------------------------
	// Condition test
	// ----------------------------------------------------------------
	// Evaluated against the flags before the command runs
	logic cond_raw;
	always_comb begin
		case (cmd[CMD_CSEL_LSB +: 2])
			CSEL_Z:  cond_raw = flags[0];
			CSEL_V:  cond_raw = flags[1];
			CSEL_C:  cond_raw = flags[2];
			CSEL_N:  cond_raw = flags[3];
			default: cond_raw = 1'b0;
		endcase
	end
	assign cond_ok = ~cmd[CMD_CEN] | (cond_raw ^ cmd[CMD_CNEG]);

	// ----------------------------------------------------------------
	// Queue flag synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_meta <= 1'b0;
			q_sync <= 1'b0;
		end else begin
			q_meta <= comm_q_i;
			q_sync <= q_meta;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE:  if (cmd_wr) state <= ST_EXEC;
				ST_EXEC: begin
					if (op == PPX_QWAIT) begin
						state <= ST_QWAIT;
					end else if ((op == PPX_LOAD || op == PPX_STORE) && cond_ok) begin
						state <= ST_MEM;
					end else if (op == PPX_MOVE && cmd[CMD_GLOB] && cond_ok) begin
						state <= ST_GLOB; // RULE16
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_MEM:   if (mem_ack_i) state <= ST_IDLE;
				ST_GLOB:  state <= ST_IDLE;
				ST_QWAIT: if (!q_sync) state <= ST_IDLE; // RULE6
				default:  state <= ST_IDLE;
			endcase
		end
	end

	// Stall shows while the flow waits on the queue flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stall_o <= 1'b0;
		end else begin
			stall_o <= (state == ST_EXEC && op == PPX_QWAIT) ||
				(state == ST_QWAIT && q_sync);
		end
	end

	// ----------------------------------------------------------------
	// Global controls
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gie_o     <= RST_GIE;
			loop_en_o <= RST_LOOP;
		end else if (state == ST_EXEC) begin
			if (op == PPX_DINT) gie_o <= 1'b0;      // RULE3
			if (op == PPX_EINT) gie_o <= 1'b1;      // RULE3
			if (op == PPX_DLOOP) loop_en_o <= 1'b0; // RULE4
			if (op == PPX_ELOOP) loop_en_o <= 1'b1; // RULE4
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Only the divide step and function fetch touch flags; nop does not
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags <= 4'h0;
		end else if (state == ST_EXEC && cond_ok && !cmd[CMD_PRO]) begin // RULE17
			if (op == PPX_DIVI) begin
				flags <= {div_rem[31], div_qbit, 1'b0, div_rem == RST_WORD};
			end else if (op == PPX_FUNC) begin
				flags <= {feff[31], 2'h0, feff == RST_WORD};
			end
		end
	end

	// ----------------------------------------------------------------
	// Global unit path
	// ----------------------------------------------------------------
	// The global move takes one extra cycle through its own holding register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gbuf    <= RST_WORD;
			gpath_o <= 1'b0;
			gused   <= 1'b0;
		end else begin
			gpath_o <= (state == ST_EXEC && op == PPX_MOVE && cmd[CMD_GLOB] && cond_ok);
			if (state == ST_EXEC && op == PPX_MOVE && cond_ok) begin
				gbuf  <= srcv;          // RULE16
				gused <= cmd[CMD_GLOB];
			end
		end
	end

	// ----------------------------------------------------------------
	// Memory port
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_req_o   <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_addr_o  <= RST_WORD;
			mem_be_o    <= 4'h0;
			mem_wdata_o <= RST_WORD;
		end else if (state == ST_EXEC && cond_ok &&
			(op == PPX_LOAD || op == PPX_STORE)) begin
			mem_req_o   <= 1'b1;                  // RULE7 RULE8
			mem_we_o    <= (op == PPX_STORE);
			mem_addr_o  <= ea;
			mem_wdata_o <= ppx_repl(srcv, size); // Data on every lane
			case (size)
				SIZE_BYTE: mem_be_o <= 4'h1 << ea[1:0];           // RULE20
				SIZE_HALF: mem_be_o <= ea[1] ? 4'hC : 4'h3;       // RULE20
				default:   mem_be_o <= 4'hF;                      // RULE12
			endcase
		end else if (mem_ack_i) begin
			mem_req_o <= 1'b0;
			mem_we_o  <= 1'b0;
			mem_be_o  <= 4'h0;
		end
	end

	// ----------------------------------------------------------------
	// Core registers
	// ----------------------------------------------------------------
	// Data-unit writes win over a bus write to the same register
	for (genvar gi = 0; gi < 8; gi++) begin : g_creg
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				creg[gi] <= RST_WORD;
			end else if (state == ST_MEM && mem_ack_i && !mem_we_o && dst == 3'(gi)) begin
				creg[gi] <= ppx_pick(mem_rdata_i, size, // RULE7
					mem_addr_o[1:0] >> (size == SIZE_HALF), sgn); // Half index in bit 1
			end else if (state == ST_GLOB && dst == 3'(gi)) begin
				creg[gi] <= gbuf;                                   // RULE16
			end else if (state == ST_EXEC && cond_ok && dst == 3'(gi)) begin // RULE19
				case (op)
					PPX_DIVI:  creg[gi] <= div_rem;                     // RULE1
					PPX_ADDR:  creg[gi] <= ea;                          // RULE9
					PPX_MOVE:  if (!cmd[CMD_GLOB]) creg[gi] <= srcv;    // RULE18
					PPX_EXTR:  creg[gi] <= ppx_pick(srcv, size, item, sgn); // RULE13
					PPX_REPL:  creg[gi] <= ppx_repl(srcv, size);        // RULE11
					PPX_FUNC:  creg[gi] <= feff;                        // RULE15
					default:   creg[gi] <= creg[gi];                    // RULE5
				endcase
			end else if (state == ST_EXEC && cond_ok && op == PPX_DIVI &&
				cmd[CMD_DST2_LSB +: 3] == 3'(gi)) begin
				creg[gi] <= div_quo;                                // RULE2
			end else if (bus_req && we_i && (adr_i & ADDR_CREG_M) == ADDR_CREG &&
				adr_i[4:2] == 3'(gi)) begin
				creg[gi] <= dat_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd  <= RST_WORD;
			base <= RST_WORD;
			offs <= RST_WORD;
			func <= RST_WORD;
		end else begin
			if (cmd_wr) cmd <= dat_i;
			if (bus_req && we_i && adr_i == ADDR_BASE) base <= dat_i;
			if (bus_req && we_i && adr_i == ADDR_OFFS) offs <= dat_i;
			if (bus_req && we_i && adr_i == ADDR_FUNC) func <= dat_i;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone answer
	// ----------------------------------------------------------------
	// One wait state; unmapped reads give zero, unmapped writes are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= RST_WORD;
		end else begin
			ack_o <= bus_req;
			dat_o <= RST_WORD;
			if (bus_req && !we_i) begin
				if ((adr_i & ADDR_CREG_M) == ADDR_CREG) begin
					dat_o <= creg[adr_i[4:2]];
				end else begin
					case (adr_i)
						ADDR_CMD:  dat_o <= cmd;
						ADDR_BASE: dat_o <= base;
						ADDR_OFFS: dat_o <= offs;
						ADDR_FUNC: dat_o <= func;
						ADDR_FEFF: dat_o <= feff;
						ADDR_STAT: begin
							dat_o[STAT_BUSY]         <= (state != ST_IDLE);
							dat_o[STAT_GIE]          <= gie_o;
							dat_o[STAT_LOOP]         <= loop_en_o;
							dat_o[STAT_QWAIT]        <= (state == ST_QWAIT);
							dat_o[STAT_GUSED]        <= gused;
							dat_o[STAT_FLAG +: 4]    <= flags;
						end
						default:   dat_o <= RST_WORD;
					endcase
				end
			end
		end
	end
endmodule : ppx_core

`default_nettype wire

// file: test/ppx_mem_model.sv
// Behavioural on-chip memory behind the crossbar, with byte lanes.
`timescale 1ns/1ns
`default_nettype none
module ppx_mem_model (
	input  wire logic        clk_i,   // Core clock
	input  wire logic        rst_i,   // Synchronous reset
	input  wire logic [3:0]  lat_i,   // Wait cycles before each answer
	input  wire logic        req_i,   // Access pending
	input  wire logic        we_i,    // 1 = store
	input  wire logic [31:0] addr_i,  // Byte address
	input  wire logic [3:0]  be_i,    // Byte lanes
	input  wire logic [31:0] wdata_i, // Store data
	output logic             ack_o,   // One-cycle answer
	output logic      [31:0] rdata_o  // Load data, valid with ack_o only
);
	logic [31:0] mem [64]; // Word store
	logic [3:0]  cnt;      // Wait cycles spent
	// ----------------
	// Answer logic
	// ----------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt     <= 4'h0;
			ack_o   <= 1'b0;
			rdata_o <= 32'h0;
		end else begin
			ack_o   <= 1'b0;
			// Toggles between answers to expose stale reads
			rdata_o <= ~rdata_o;
			// The request is still seen during ack, so skip that cycle
			if (req_i && !ack_o) begin
				if (cnt == lat_i) begin
					cnt     <= 4'h0;
					ack_o   <= 1'b1;
					rdata_o <= mem[addr_i[7:2]];
					// Only enabled lanes change
					for (int i = 0; i < 4; i++)
						if (we_i && be_i[i]) mem[addr_i[7:2]][8*i+:8] <= wdata_i[8*i+:8];
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule : ppx_mem_model
`default_nettype wire

// file: test/ppx_core_properties.sv
// Concurrent checks on the transfer core's bus, memory and control ports.
`timescale 1ns/1ns
`default_nettype none
module ppx_core_properties
	import ppx_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic        ack_o,
	input wire logic        mem_req_o,
	input wire logic        mem_we_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [3:0]  mem_be_o,
	input wire logic        mem_ack_i,
	input wire logic        comm_q_i,
	input wire logic        gie_o,
	input wire logic        loop_en_o,
	input wire logic        stall_o,
	input wire logic        gpath_o
);
	// ----------------
	// Helpers
	// ----------------
	logic       req; // Bus request not yet answered
	logic [3:0] cop; // Operation of a command write, all ones otherwise
	assign req = cyc_i && stb_i && !ack_o;
	assign cop = (req && we_i && adr_i == ADDR_CMD) ? dat_i[3:0] : 4'hF;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------
	// Assertions
	// ----------------
	a_ack_after_req: assert property (req |=> ack_o) else $error("ack late");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_ack_cause: assert property (ack_o |-> $past(req)) else $error("ack unasked");
	a_gie_set: assert property ($rose(gie_o) |-> $past(cop, 2) == PPX_EINT)
		else $error("gie set without enable");
	a_gie_clear: assert property ($fell(gie_o) |-> $past(cop, 2) == PPX_DINT)
		else $error("gie cleared without disable");
	a_loop_set: assert property ($rose(loop_en_o) |-> $past(cop, 2) == PPX_ELOOP)
		else $error("loop set without enable");
	a_loop_clear: assert property ($fell(loop_en_o) |-> $past(cop, 2) == PPX_DLOOP)
		else $error("loop cleared without disable");
	a_stall_start: assert property ($rose(stall_o) |-> $past(cop, 2) == PPX_QWAIT)
		else $error("stall without queue wait");
	a_stall_hold: assert property (stall_o && comm_q_i |=> stall_o)
		else $error("stall ended with flag set");
	a_stall_end: assert property ($fell(comm_q_i) ##1 (!comm_q_i) [*5] |=> !stall_o)
		else $error("stall outlived flag");
	a_mem_hold: assert property (mem_req_o && !mem_ack_i |=>
		mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o)) else $error("access unstable");
	a_mem_single: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
		else $error("access kept after answer");
	a_store_lanes: assert property (mem_req_o && mem_we_o |-> mem_be_o == 4'hF ||
		mem_be_o == 4'h1 << mem_addr_o[1:0] || mem_be_o == (mem_addr_o[1] ? 4'hC : 4'h3))
		else $error("bad store lanes");
	a_gpath_pulse: assert property (gpath_o |=> !gpath_o) else $error("gpath too long");
	c_load: cover property (mem_req_o && mem_ack_i && !mem_we_o);
	c_store: cover property (mem_req_o && mem_ack_i && mem_we_o);
	c_qwait: cover property ($fell(stall_o));
	c_global: cover property (gpath_o);
endmodule : ppx_core_properties

bind ppx_core ppx_core_properties ppx_core_properties_inst (.*);
`default_nettype wire

// file: test/ppx_core_bench.sv
// Self-checking bench for the transfer core and its memory partner.
`timescale 1ns/1ns
`default_nettype none
module ppx_core_bench;
	import ppx_pkg::*;
	// ----------------
	// Signals, command bits and counters
	// ----------------
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic        comm_q_i = 1'b0, ack_o, mem_req_o, mem_we_o, mem_ack_i;
	logic        gie_o, loop_en_o, stall_o, gpath_o;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'hF, lat = 4'h0, mem_be_o;
	logic [31:0] dat_i = 32'h0, dat_o, mem_addr_o, mem_wdata_o, mem_rdata_i, q;
	int          num_errors = 0, n_compared = 0, gcnt = 0, mcnt = 0;
	localparam logic [31:0] SRC = 32'h8A7B_C4D5; // Pattern with sign bits set
	localparam logic [31:0] BYT = 32'h10, HLF = 32'h20, SGN = 32'h100, GLB = 32'h200;
	localparam logic [31:0] CEN = 32'h400, CNG = 32'h800, PRO = 32'h4000, CMP = 32'h8000;
	always #10 clk_i = ~clk_i;
	// Count global-path pulses and memory busy cycles
	always @(posedge clk_i) begin
		if (gpath_o === 1'b1) gcnt <= gcnt + 1;
		if (mem_req_o === 1'b1) mcnt <= mcnt + 1;
	end
	ppx_core ppx_core_inst (.*);
	ppx_mem_model ppx_mem_model_inst (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat),
		.req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o), .be_i(mem_be_o),
		.wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
	// ----------------
	// Helpers
	// ----------------
	function automatic logic [31:0] cw(ppx_op_type o, int d, int s);
		return 32'(o) | (32'(d) << CMD_DST_LSB) | (32'(s) << CMD_SRC_LSB);
	endfunction : cw
	function automatic logic [7:0] ra(int i);
		return ADDR_CREG + 8'(4 * i);
	endfunction : ra
	// Right-aligned field of width w at slot it, zero or sign filled
	function automatic logic [31:0] fld(logic [31:0] v, int w, int it, bit s);
		logic [31:0] m;
		m = (32'h1 << w) - 32'h1;
		v = (v >> (w * it)) & m;
		return (s && v[w-1]) ? (v | ~m) : v;
	endfunction : fld
	task automatic end_sim;
		if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic tmo(input string n);
		check(n, 32'h1, 32'h0);
		end_sim();
	endtask : tmo
	// One classic cycle; holds everything until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		for (k = 0; k < 20 && ack_o !== 1'b1; k++) @(posedge clk_i);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (k == 20) tmo("bus ack");
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask : wr
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(n, q, e);
	endtask : rc
	// Poll status until not busy
	task automatic idle;
		int k;
		for (k = 0; k < 60; k++) begin
			wb(1'b0, ADDR_STAT, 32'h0);
			if (q[STAT_BUSY] === 1'b0) break;
		end
		if (k == 60) tmo("busy");
	endtask : idle
	task automatic run(input logic [31:0] c);
		wr(ADDR_CMD, c);
		idle();
	endtask : run
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		int k;
		logic [31:0] dv;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rc("status", ADDR_STAT, 32'h0);
		run(cw(PPX_EINT, 0, 0));
		check("gie", 32'(gie_o), 32'h1);
		run(cw(PPX_ELOOP, 0, 0));
		check("loop", 32'(loop_en_o), 32'h1);
		run(cw(PPX_DINT, 0, 0));
		check("gie", 32'(gie_o), 32'h0);
		run(cw(PPX_DLOOP, 0, 0));
		check("loop", 32'(loop_en_o), 32'h0);
		wr(8'hFC, 32'hFFFF_FFFF);
		rc("unmapped", 8'hFC, 32'h0);
		wr(ra(1), SRC);
		wr(ra(3), 32'h0);
		run(cw(PPX_NOP, 0, 0));
		rc("nop", ra(1), SRC);
		run(cw(PPX_MOVE, 2, 1));
		rc("move", ra(2), SRC);
		run(cw(PPX_MOVE, 3, 1) | CEN);
		rc("cond false", ra(3), 32'h0);
		run(cw(PPX_MOVE, 3, 1) | CEN | CNG);
		rc("cond true", ra(3), SRC);
		k = gcnt;
		run(cw(PPX_MOVE, 4, 1) | GLB);
		check("gpath", 32'(gcnt - k), 32'h1);
		rc("global move", ra(4), SRC);
		for (int h = 0; h < 2; h++)
			for (int it = 0; it < 4 - 2 * h; it++)
				for (int s = 0; s < 2; s++) begin
					run(cw(PPX_EXTR, 5, 1) | (h ? HLF : BYT) | (32'(it) << CMD_ITEM_LSB) | (s ? SGN : 32'h0));
					rc("extract", ra(5), fld(SRC, 8 + 8 * h, it, s[0]));
				end
		run(cw(PPX_REPL, 6, 1) | BYT);
		rc("repl byte", ra(6), {4{SRC[7:0]}});
		run(cw(PPX_REPL, 6, 1) | HLF);
		rc("repl half", ra(6), {2{SRC[15:0]}});
		wr(ADDR_BASE, 32'h40);
		wr(ADDR_OFFS, 32'h4);
		k = mcnt;
		run(cw(PPX_ADDR, 7, 0));
		rc("addr", ra(7), 32'h44);
		check("addr no access", 32'(mcnt - k), 32'h0);
		lat <= 4'h3;
		run(cw(PPX_STORE, 0, 1));
		wr(ra(0), 32'h0000_2211);
		wr(ADDR_OFFS, 32'h5);
		run(cw(PPX_STORE, 0, 0) | BYT);
		wr(ADDR_OFFS, 32'h6);
		run(cw(PPX_STORE, 0, 0) | HLF);
		lat <= 4'h0;
		run(cw(PPX_LOAD, 7, 0));
		rc("load word", ra(7), 32'h2211_11D5);
		run(cw(PPX_LOAD, 7, 0) | HLF);
		rc("load half", ra(7), 32'h0000_2211);
		wr(ADDR_OFFS, 32'h4);
		run(cw(PPX_LOAD, 7, 0) | BYT | SGN);
		rc("load sbyte", ra(7), 32'hFFFF_FFD5);
		wr(ADDR_FUNC, 32'h0);
		run(cw(PPX_FUNC, 3, 0));
		wr(ADDR_FUNC, 32'h8000_0000);
		run(cw(PPX_FUNC, 3, 0) | CEN | PRO);
		rc("protected", ra(3), 32'h8000_0000);
		wb(1'b0, ADDR_STAT, 32'h0);
		check("flags", 32'(q[11:8]), 32'h1);
		run(cw(PPX_FUNC, 3, 0) | CMP);
		rc("complement", ra(3), 32'h7FFF_FFFF);
		rc("func in effect", ADDR_FEFF, 32'h7FFF_FFFF);
		wr(ra(3), 32'h0);
		wr(ra(4), 32'd100);
		wr(ra(5), 32'd7);
		dv = cw(PPX_DIVI, 3, 4) | (32'h5 << CMD_SRC2_LSB) | (32'h4 << CMD_DST2_LSB);
		run(dv);
		rc("one step", ra(4), 32'd200);
		repeat (31) run(dv);
		rc("quotient", ra(4), 32'd14);
		rc("remainder", ra(3), 32'd2);
		comm_q_i <= 1'b1;
		wr(ADDR_CMD, cw(PPX_QWAIT, 0, 0));
		repeat (4) @(posedge clk_i);
		check("stall", 32'(stall_o), 32'h1);
		comm_q_i <= 1'b0;
		for (k = 0; k < 12 && stall_o !== 1'b0; k++) @(posedge clk_i);
		if (k == 12) tmo("stall release");
		idle();
		end_sim();
	end
endmodule : ppx_core_bench
`default_nettype wire
